//--- common/hopeng_defines.svh
`ifndef HOPENG_DEFINES_SVH
`define HOPENG_DEFINES_SVH

// ==========================================
// register offsets (byte addresses, 8-bit bus)
`define HOPENG_OFS_CTRL 5'h00
`define HOPENG_OFS_CNT_LO 5'h01
`define HOPENG_OFS_CNT_HI 5'h02
`define HOPENG_OFS_KEY0 5'h03
`define HOPENG_OFS_LUT0 5'h0b
`define HOPENG_OFS_SS0 5'h0f
`define HOPENG_OFS_SS3 5'h12
`define HOPENG_OFS_IRQ_STAT 5'h13
`define HOPENG_OFS_IRQ_MASK 5'h14

// ==========================================
// field positions
`define HOPENG_CTRL_RUN 0
`define HOPENG_CTRL_DIR 1
`define HOPENG_IRQ_DONE 0

// ==========================================
// reset values and widths
`define HOPENG_RST_BYTE 8'h00
`define HOPENG_KEY_BYTES 8
`define HOPENG_LUT_BYTES 4
`define HOPENG_SS_BYTES 4

`endif

//--- common/hopeng_pkg.sv
package hopeng_pkg;

	// engine sequencer, one-hot
	typedef enum logic [1:0] {
		HOPENG_IDLE = 2'b01,
		HOPENG_RUN = 2'b10
	} hopeng_state_t;

	// register-bus request
	typedef struct packed {
		logic [4:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} hopeng_bus_t;

	// whole block state
	typedef struct packed {
		hopeng_state_t fsm;
		logic dir;
		logic [15:0] count;
		logic [63:0] key;
		logic [31:0] lut;
		logic [31:0] shift;
		logic [5:0] dec_bit;
		logic done_stat;
		logic done_mask;
		logic [7:0] rdata;
		logic irq;
	} hopeng_regs_t;

endpackage

//--- core/hopeng_core.sv
// Chosen here: the strobed register port and the address map.
`timescale 1ns/10ps
`include "hopeng_defines.svh"

module hopeng_core
	import hopeng_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// register port
	input wire logic [4:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// engine status
	output logic busy_o,
	output logic irq_o
);

	// ==========================================
	// state
	hopeng_regs_t r;
	hopeng_regs_t next_r;
	hopeng_bus_t bus;
	logic running;
	logic [4:0] enc_idx;
	logic [4:0] dec_idx;
	logic enc_fb;
	logic dec_fb;
	logic [7:0] key_rd [0:7];
	logic [7:0] lut_rd [0:3];
	logic [7:0] ss_rd [0:3];

	assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
	// one-hot run code, so busy_o is the run flop itself
	assign running = r.fsm[1];

	// byte views of the wide registers
	genvar gi;
	generate
		for (gi = 0; gi < `HOPENG_KEY_BYTES; gi++) begin : g_key
			assign key_rd[gi] = r.key[gi*8 +: 8];
		end
		for (gi = 0; gi < `HOPENG_LUT_BYTES; gi++) begin : g_lut
			assign lut_rd[gi] = r.lut[gi*8 +: 8];
		end
		for (gi = 0; gi < `HOPENG_SS_BYTES; gi++) begin : g_ss
			assign ss_rd[gi] = r.shift[gi*8 +: 8];
		end
	endgenerate

	// feedback bits for both directions
	assign enc_idx = {r.shift[31], r.shift[26], r.shift[20], r.shift[9], r.shift[1]};
	assign dec_idx = {r.shift[30], r.shift[25], r.shift[19], r.shift[8], r.shift[0]};
	assign enc_fb = r.shift[0] ^ r.shift[16] ^ r.key[0] ^ r.lut[enc_idx];
	assign dec_fb = r.shift[31] ^ r.shift[15] ^ r.key[r.dec_bit] ^ r.lut[dec_idx];

	// ==========================================
	// next state
	always_comb begin
		logic [4:0] a;
		logic [15:0] cnt_dec;
		a = bus.addr;
		cnt_dec = r.count - 16'h0001;
		next_r = r;
		next_r.rdata = 8'h00;
		// interrupt status clears on write-one; completion set below wins
		if (bus.wr && a == `HOPENG_OFS_IRQ_STAT && bus.wdata[`HOPENG_IRQ_DONE]) begin
			next_r.done_stat = 1'b0;
		end
		if (bus.wr && a == `HOPENG_OFS_IRQ_MASK) begin
			next_r.done_mask = bus.wdata[`HOPENG_IRQ_DONE];
		end
		unique case (r.fsm)
			HOPENG_IDLE: begin
				// parameter writes only accepted while idle
				if (bus.wr) begin
					if (a == `HOPENG_OFS_CNT_LO) begin
						next_r.count[7:0] = bus.wdata;
					end
					if (a == `HOPENG_OFS_CNT_HI) begin
						next_r.count[15:8] = bus.wdata;
					end
					for (int i = 0; i < `HOPENG_KEY_BYTES; i++) begin
						if (a == `HOPENG_OFS_KEY0 + 5'(i)) begin
							next_r.key[i*8 +: 8] = bus.wdata;
						end
					end
					for (int i = 0; i < `HOPENG_LUT_BYTES; i++) begin
						if (a == `HOPENG_OFS_LUT0 + 5'(i)) begin
							next_r.lut[i*8 +: 8] = bus.wdata;
						end
						if (a == `HOPENG_OFS_SS0 + 5'(i)) begin
							next_r.shift[i*8 +: 8] = bus.wdata;
						end
					end
					if (a == `HOPENG_OFS_CTRL) begin
						next_r.dir = bus.wdata[`HOPENG_CTRL_DIR];
						// zero count: run bit drops at once, no event
						if (bus.wdata[`HOPENG_CTRL_RUN] && r.count != 16'h0000) begin
							next_r.fsm = HOPENG_RUN;
							next_r.dec_bit = 6'(r.count - 16'h0001);
						end
					end
				end
			end
			HOPENG_RUN: begin
				// one round per clock; control writes ignored meanwhile
				if (r.dir) begin
					next_r.shift = {r.shift[30:0], dec_fb};
					next_r.key = {r.key[62:0], r.key[63]};
				end else begin
					next_r.shift = {enc_fb, r.shift[31:1]};
					next_r.key = {r.key[0], r.key[63:1]};
				end
				next_r.count = cnt_dec;
				if (cnt_dec == 16'h0000) begin
					next_r.fsm = HOPENG_IDLE;
					next_r.done_stat = 1'b1;
				end
			end
		endcase
		// read data, valid the cycle after the strobe
		if (bus.rd) begin
			if (a == `HOPENG_OFS_CTRL) begin
				next_r.rdata = {6'h00, r.dir, running};
			end
			if (a == `HOPENG_OFS_CNT_LO) begin
				next_r.rdata = r.count[7:0];
			end
			if (a == `HOPENG_OFS_CNT_HI) begin
				next_r.rdata = r.count[15:8];
			end
			for (int i = 0; i < `HOPENG_KEY_BYTES; i++) begin
				if (a == `HOPENG_OFS_KEY0 + 5'(i)) begin
					next_r.rdata = key_rd[i];
				end
			end
			for (int i = 0; i < `HOPENG_LUT_BYTES; i++) begin
				if (a == `HOPENG_OFS_LUT0 + 5'(i)) begin
					next_r.rdata = lut_rd[i];
				end
				if (a == `HOPENG_OFS_SS0 + 5'(i)) begin
					next_r.rdata = ss_rd[i];
				end
			end
			if (a == `HOPENG_OFS_IRQ_STAT) begin
				next_r.rdata = {7'h00, r.done_stat};
			end
			if (a == `HOPENG_OFS_IRQ_MASK) begin
				next_r.rdata = {7'h00, r.done_mask};
			end
		end
		// level interrupt registered from the next-state flag and mask
		next_r.irq = next_r.done_stat & next_r.done_mask;
	end

	// ==========================================
	// registers
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			r <= '{fsm: HOPENG_IDLE, default: '0};
		end else begin
			r <= next_r;
		end
	end

	// outputs straight from flops
	assign rdata_o = r.rdata;
	assign busy_o = running;
	assign irq_o = r.irq;

endmodule

//--- verif/hopeng_core_tb.sv
`timescale 1ns/10ps
// ==========
// bench
module hopeng_core_tb;
	logic clk = 0, rst_b = 0, w = 0, r = 0, busy, irq;
	logic [4:0] a = 0;
	logic [7:0] d = 0, q;
	logic [119:0] p;
	logic [31:0] s;
	int cmp_count = 0, bad_count = 0, i;
	// clock
	initial forever #5 clk = ~clk;
	hopeng_core u_hopeng_core(.ref_clk_i(clk), .rst_b_i(rst_b), .addr_i(a), .wdata_i(d), .wr_i(w),
		.rd_i(r), .rdata_o(q), .busy_o(busy), .irq_o(irq));
	// rounds of the engine
	function logic [31:0] f(input logic [63:0] k, input logic [31:0] l, s, input logic [15:0] n, input logic e);
		logic [5:0] m;
		logic b;
		m = 6'(n - 1);
		repeat (n) if (e) begin
			b = s[31] ^ s[15] ^ k[m] ^ l[{s[30], s[25], s[19], s[8], s[0]}];
			s = {s[30:0], b};
			k = {k[62:0], k[63]};
		end else begin
			b = s[0] ^ s[16] ^ k[0] ^ l[{s[31], s[26], s[20], s[9], s[1]}];
			s = {b, s[31:1]};
			k = {k[0], k[63:1]};
		end
		return s;
	endfunction
	task chk(input logic [7:0] g, e);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task wb(input logic [4:0] x, input logic [7:0] y);
		@(posedge clk);
		a <= x;
		d <= y;
		w <= 1;
		@(posedge clk);
		w <= 0;
		#1;
	endtask
	task rb(input logic [4:0] x, input logic [7:0] e);
		@(posedge clk);
		a <= x;
		r <= 1;
		@(posedge clk);
		r <= 0;
		#1 chk(q, e);
	endtask
	task ld;
		for (i = 0; i < 15; i++) wb(5'(3 + i), p[8*i+:8]);
	endtask
	task ck;
		for (i = 0; i < 15; i++) rb(5'(3 + i), p[8*i+:8]);
	endtask
	// locked writes land mid-run, so any leak spoils the result
	task go(input logic [15:0] n, input logic e);
		int j;
		s = f(p[63:0], p[95:64], {s[31:24], p[119:96]}, n, e);
		wb(5'h01, n[7:0]);
		wb(5'h02, n[15:8]);
		wb(5'h00, {6'h00, e, 1'b1});
		chk({7'h00, busy}, 8'h01);
		wb(5'h03, 8'hff);
		wb(5'h0b, 8'hff);
		wb(5'h0f, 8'hff);
		rb(5'h00, {6'h00, e, 1'b1});
		for (j = 0; j < 200 && busy !== 1'b0; j++) #10;
		chk({7'h00, busy}, 8'h00);
		rb(5'h00, {6'h00, e, 1'b0});
		rb(5'h01, 8'h00);
		for (i = 0; i < 4; i++) rb(5'(15 + i), s[8*i+:8]);
		rb(5'h13, 8'h01);
	endtask
	task results;
		$display("cmp=%0d bad=%0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// watchdog
	initial begin
		#30000;
		bad_count++;
		results;
	end
	// tests
	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1;
		p = 0;
		s = 0;
		rb(5'h02, 8'h00);
		ck;
		p = {24'h5a3c96, 32'hc3a5f00f, 64'h0123456789abcdef};
		ld;
		ck;
		wb(5'h02, 8'h7e);
		rb(5'h02, 8'h7e);
		$display("registers done");
		wb(5'h14, 8'h01);
		go(16'h0009, 1'b0);
		chk({7'h00, irq}, 8'h01);
		wb(5'h14, 8'h00);
		chk({7'h00, irq}, 8'h00);
		wb(5'h14, 8'h01);
		chk({7'h00, irq}, 8'h01);
		wb(5'h13, 8'h01);
		chk({7'h00, irq}, 8'h00);
		rb(5'h13, 8'h00);
		rb(5'h1f, 8'h00);
		wb(5'h00, 8'h01);
		chk({7'h00, busy}, 8'h00);
		rb(5'h13, 8'h00);
		$display("encrypt done");
		p = {24'h17e2a4, 32'h9d6b3e51, 64'hfedcba9876543210};
		ld;
		go(16'h0046, 1'b1);
		$display("decrypt done");
		results;
	end
endmodule
bind hopeng_core hopeng_monitor u_hopeng_monitor(.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.busy_o(busy_o), .irq_o(irq_o));

//--- verif/hopeng_monitor.sv
`timescale 1ns/10ps
// ==========
// port checker
module hopeng_monitor(
	// clock, reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// watched bus
	input wire logic [4:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic busy_o,
	input wire logic irq_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	property p_rz; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
	property p_go; $rose(busy_o) |-> $past(wr_i && addr_i == 5'h00 && wdata_i[0]); endproperty
	property p_ir; $rose(irq_o) |-> $fell(busy_o) || $past(wr_i && addr_i == 5'h14); endproperty
	property p_rn; rd_i && addr_i == 5'h00 |=> rdata_o[0] == $past(busy_o); endproperty
	property p_un; rd_i && addr_i > 5'h14 |=> rdata_o == 8'h00; endproperty
	property p_fl; $fell(irq_o) |-> $past(wr_i && addr_i inside {5'h13, 5'h14}); endproperty
	property p_wc; wr_i && addr_i == 5'h13 && wdata_i[0] && !busy_o |=> !irq_o; endproperty
	property p_mk; wr_i && addr_i == 5'h14 && !wdata_i[0] |=> !irq_o; endproperty
	a_rz: assert property (p_rz) else $error("stray data");
	a_go: assert property (p_go) else $error("bad start");
	a_ir: assert property (p_ir) else $error("bad irq rise");
	a_rn: assert property (p_rn) else $error("bad run bit");
	a_un: assert property (p_un) else $error("unmapped data");
	a_fl: assert property (p_fl) else $error("bad irq fall");
	a_wc: assert property (p_wc) else $error("clear lost");
	a_mk: assert property (p_mk) else $error("mask lost");
endmodule
